// ==== hw/mem_side_strap_and_select.sv ====
// strap capture, eeprom load window and local memory strobes/selects
// assumes pins are synchronous to core_clk; pads resolve from the enables
`timescale 1ns/1ns
module mem_side_strap_and_select
  import strap_select_pkg::*;
#(
  parameter int eeprom_cycles = eeprom_bits
)(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire strap_select_pkg::mem_req_t req,
  output logic req_ready,
  output logic req_done,
  output logic [data_w-1:0] rdata,
  input wire logic [upper_addr_w-1:0] upper_local_addr_lines_in,
  output logic [upper_addr_w-1:0] upper_local_addr_lines_out,
  output logic upper_local_addr_lines_oe,
  input wire logic [data_w-1:0] local_data_lines_in,
  output logic [data_w-1:0] local_data_lines_out,
  output logic local_data_lines_oe,
  output logic eeprom_lines_busy,
  output logic local_read_strobe_n,
  output logic local_write_strobe_n,
  output logic packet_ram_select_n,
  output logic boot_rom_select_n,
  output logic serial_eeprom_select,
  output strap_select_pkg::strap_t straps,
  output logic config_ready
);
  import strap_select_pkg::*;

  state_t state_q;
  strap_t straps_q;
  logic [15:0] ee_cnt_q;
  mem_req_t cur_q;
  logic [data_w-1:0] rdata_q;
  logic done_q;

  // straps track the pins while in reset; last value is kept at release
  always_ff @(posedge core_clk)
  begin
    if (state_q == st_reset)
    begin
      straps_q.bus16 <= upper_local_addr_lines_in[pos_bus_width];
      straps_q.cfg_from_eeprom <= upper_local_addr_lines_in[pos_cfg_src];
      straps_q.id_hi <= upper_local_addr_lines_in[pos_id_lo +: id_w];
      straps_q.cfg_a <= local_data_lines_in[cfg_a_w-1:0];
    end
  end

  // sequence: reset -> optional eeprom window -> idle/access
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_q <= st_reset;
      ee_cnt_q <= 16'h0000;
      cur_q <= '0;
    end
    else
    begin
      unique case (state_q)
        st_reset:
        begin
          ee_cnt_q <= 16'h0000;
          state_q <= straps_q.cfg_from_eeprom ? st_eeprom : st_idle;
        end
        st_eeprom:
        begin
          ee_cnt_q <= ee_cnt_q + 16'h0001;
          if (ee_cnt_q == 16'(eeprom_cycles - 1))
            state_q <= st_idle;
        end
        st_idle:
          if (req.valid)
          begin
            cur_q <= req;
            state_q <= st_access;
          end
        st_access:
          state_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rdata_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == st_access);
      if (state_q == st_access && !cur_q.write)
        rdata_q <= local_data_lines_in;
    end
  end

  logic acc;
  assign acc = (state_q == st_access);
  assign req_ready = (state_q == st_idle);
  assign req_done = done_q;
  assign rdata = rdata_q;
  assign config_ready = (state_q == st_idle) || acc;
  assign straps = straps_q;
  assign eeprom_lines_busy = (state_q == st_eeprom);

  assign upper_local_addr_lines_oe = (state_q != st_reset);
  assign upper_local_addr_lines_out = acc ? cur_q.upper_addr : upper_addr_rst;
  assign local_data_lines_oe = acc && cur_q.write
    && (cur_q.target == tgt_ram);
  assign local_data_lines_out = cur_q.wdata;
  assign local_read_strobe_n = !(acc && !cur_q.write);
  assign local_write_strobe_n = !(acc && cur_q.write
    && (cur_q.target == tgt_ram));
  assign packet_ram_select_n = !(acc && cur_q.target == tgt_ram);
  assign boot_rom_select_n = !(acc && !cur_q.write
    && cur_q.target == tgt_rom);
  assign serial_eeprom_select = (state_q == st_eeprom)
    || (acc && !cur_q.write && cur_q.target == tgt_eeprom);

  // every check is gated by reset except strap_undriven_a, which has to
  // look inside the reset window itself
  rom_read_only_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !boot_rom_select_n |-> local_write_strobe_n)
    else $error("rom select with write strobe");
  rom_write_refused_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_ready && req.valid && req.write && req.target != tgt_ram |=>
    boot_rom_select_n && local_write_strobe_n && !local_data_lines_oe
    && packet_ram_select_n && !serial_eeprom_select)
    else $error("refused write produced a strobe or select");
  rom_read_sel_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_ready && req.valid && !req.write && req.target == tgt_rom |=>
    !boot_rom_select_n && packet_ram_select_n && !serial_eeprom_select)
    else $error("rom read without rom select");
  addr_drive_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) ##1 1'b1 |-> upper_local_addr_lines_oe)
    else $error("address lines not driven after reset");
  addr_out_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_ready && req.valid |=> upper_local_addr_lines_oe
    && upper_local_addr_lines_out == $past(req.upper_addr))
    else $error("access address not on upper lines");
  strap_undriven_a: assert property (
    @(posedge core_clk)
    !reset_n ##1 !reset_n |-> !upper_local_addr_lines_oe
    && !local_data_lines_oe && local_read_strobe_n && local_write_strobe_n
    && packet_ram_select_n && boot_rom_select_n && !serial_eeprom_select)
    else $error("pins driven or strobed during reset");
  strap_hold_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $past(reset_n) && state_q != st_reset |-> $stable(straps_q))
    else $error("straps changed outside reset");
  strap_capture_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(upper_local_addr_lines_oe) |->
    straps.bus16 == $past(upper_local_addr_lines_in[pos_bus_width])
    && straps.cfg_from_eeprom
    == $past(upper_local_addr_lines_in[pos_cfg_src])
    && straps.id_hi == $past(upper_local_addr_lines_in[pos_id_lo +: id_w])
    && straps.cfg_a == $past(local_data_lines_in[cfg_a_w-1:0]))
    else $error("straps not taken from the pins at release");
  strap_src_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    state_q == st_reset ##1 state_q != st_reset |->
    eeprom_lines_busy == straps_q.cfg_from_eeprom)
    else $error("config source not honoured");
  ee_window_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(eeprom_lines_busy) |-> eeprom_lines_busy [*2])
    else $error("eeprom window too short");
  ee_length_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $fell(eeprom_lines_busy) |-> $past(ee_cnt_q) == 16'(eeprom_cycles - 1))
    else $error("eeprom window length wrong");
  ee_end_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $fell(eeprom_lines_busy) |-> state_q == st_idle)
    else $error("eeprom window did not return to idle");
  ee_select_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    eeprom_lines_busy |-> serial_eeprom_select && packet_ram_select_n)
    else $error("eeprom select missing in load");
  ee_read_sel_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_ready && req.valid && !req.write && req.target == tgt_eeprom |=>
    serial_eeprom_select && packet_ram_select_n && boot_rom_select_n)
    else $error("eeprom read without eeprom select");
  config_ready_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    state_q != st_reset |-> config_ready == !eeprom_lines_busy)
    else $error("config ready during eeprom load");
  read_strobe_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_ready && req.valid && !req.write |=> !local_read_strobe_n ##1
    local_read_strobe_n && req_done)
    else $error("read strobe timing wrong");
  ram_read_sel_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_ready && req.valid && !req.write && req.target == tgt_ram |=>
    !packet_ram_select_n && !local_read_strobe_n && !local_data_lines_oe)
    else $error("ram read without ram select");
  write_strobe_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_ready && req.valid && req.write && req.target == tgt_ram |=>
    !local_write_strobe_n && !packet_ram_select_n && local_data_lines_oe)
    else $error("write strobe or ram select missing");
  ram_wdata_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_ready && req.valid && req.write |=>
    local_data_lines_out == $past(req.wdata) && local_read_strobe_n)
    else $error("write data not presented");
  done_pulse_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_done |-> req_ready && local_read_strobe_n && local_write_strobe_n)
    else $error("completion overlaps an access");
endmodule : mem_side_strap_and_select

// ==== hw/strap_select_pkg.sv ====
// package for the local memory strap and select block
// assumes a single 10 MHz core clock and synchronous active-low reset
package strap_select_pkg;
  localparam int clk_period_ns = 100;
  localparam int upper_addr_w = 5;
  localparam int data_w = 16;
  localparam int addr_w = 8;
  localparam int cfg_a_w = 8;
  localparam int id_w = 3;
  // positions of the straps on the upper address lines
  localparam int pos_bus_width = 0;
  localparam int pos_cfg_src = 1;
  localparam int pos_id_lo = 2;
  localparam int eeprom_lines = 3;
  localparam int eeprom_bits = 64;
  localparam logic [upper_addr_w-1:0] upper_addr_rst = 5'h00;
  localparam logic [cfg_a_w-1:0] cfg_a_rst = 8'h00;
  localparam logic [id_w-1:0] id_rst = 3'h0;

  typedef enum logic [1:0] {
    tgt_ram = 2'h0,
    tgt_rom = 2'h1,
    tgt_eeprom = 2'h2
  } target_t;

  typedef struct packed {
    logic bus16;
    logic cfg_from_eeprom;
    logic [id_w-1:0] id_hi;
    logic [cfg_a_w-1:0] cfg_a;
  } strap_t;

  typedef struct packed {
    logic valid;
    logic write;
    target_t target;
    logic [upper_addr_w-1:0] upper_addr;
    logic [data_w-1:0] wdata;
  } mem_req_t;

  typedef enum logic [1:0] {
    st_reset = 2'b00,
    st_eeprom = 2'b01,
    st_idle = 2'b11,
    st_access = 2'b10
  } state_t;
endpackage : strap_select_pkg

// ==== test/mem_partner.sv ====
// far-side model: packet ram, boot rom and strap resistors on the pads
// assumes the device enables decide who drives each pad
`timescale 1ns/1ns
module mem_partner
  import strap_select_pkg::*;
(
  input wire logic clk,
  input wire logic aoe,
  input wire logic doe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ram_n,
  input wire logic rom_n,
  input wire logic ee,
  input wire logic [upper_addr_w-1:0] sup,
  input wire logic [upper_addr_w-1:0] aout,
  input wire logic [data_w-1:0] sdat,
  input wire logic [data_w-1:0] dout,
  output logic [upper_addr_w-1:0] apad,
  output logic [data_w-1:0] dpad
);
  logic [data_w-1:0] ram_q [32];
  always_ff @(posedge clk)
    if (!wr_n && !ram_n && doe)
      ram_q[aout] <= dout;
  // undriven upper lines rest at the strap resistor levels
  assign apad = aoe ? aout : sup;
  // the data strap resistors stay on the board, so an idle bus shows them
  always_comb
    if (doe)
      dpad = dout;
    else if (!rd_n && !ram_n)
      dpad = ram_q[aout];
    else if (!rd_n && !rom_n)
      dpad = {11'h000, ~aout};
    else if (!rd_n && ee)
      dpad = {aout, 11'h000};
    else
      dpad = sdat;
endmodule : mem_partner

// ==== test/mem_side_strap_and_select_test.sv ====
// self-checking bench for the strap and select block
// assumes mem_partner resolves the pads from the device enables
`timescale 1ns/1ns
module mem_side_strap_and_select_test;
  import strap_select_pkg::*;
  logic clk, rst_n, rdy, done, aoe, doe, busy, rd_n, wr_n, ram_n, rom_n, ee;
  logic cfg_rdy;
  mem_req_t req;
  strap_t st;
  logic [data_w-1:0] rdata, dout, dpad, sdat;
  logic [upper_addr_w-1:0] aout, apad, sup;
  logic [data_w-1:0] model [32];
  logic [31:0] rv;
  int n_errors, checks_done, seed;
  mem_side_strap_and_select #(.eeprom_cycles(4)) i_dut(.core_clk(clk),
    .reset_n(rst_n), .req(req), .req_ready(rdy), .req_done(done),
    .rdata(rdata), .upper_local_addr_lines_in(apad),
    .upper_local_addr_lines_out(aout), .upper_local_addr_lines_oe(aoe),
    .local_data_lines_in(dpad), .local_data_lines_out(dout),
    .local_data_lines_oe(doe), .eeprom_lines_busy(busy),
    .local_read_strobe_n(rd_n), .local_write_strobe_n(wr_n),
    .packet_ram_select_n(ram_n), .boot_rom_select_n(rom_n),
    .serial_eeprom_select(ee), .straps(st), .config_ready(cfg_rdy));
  mem_partner i_mem(.clk(clk), .aoe(aoe), .doe(doe), .rd_n(rd_n),
    .wr_n(wr_n), .ram_n(ram_n), .rom_n(rom_n), .ee(ee), .sup(sup),
    .aout(aout), .sdat(sdat), .dout(dout), .apad(apad), .dpad(dpad));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] sexp(logic [4:0] u, logic [15:0] d);
    return {19'h0, u[0], u[1], u[4:2], d[7:0]};
  endfunction : sexp
  function automatic logic [31:0] rexp(target_t t, logic [4:0] a);
    if (t == tgt_ram)
      return model[a];
    if (t == tgt_rom)
      return {11'h000, ~a};
    return {a, 11'h000};
  endfunction : rexp
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic do_reset(logic [4:0] u, logic [15:0] d);
    @(posedge clk);
    rst_n <= 1'b0;
    sup <= u;
    sdat <= d;
    repeat (6) @(posedge clk);
    #1 check("oe in reset", {aoe, doe, ee}, 0);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check("straps", st, sexp(u, d));
    check("addr oe", aoe, 1);
    check("window", {busy, ee}, {2{u[1]}});
    check("cfg ready", cfg_rdy, !u[1]);
    repeat (6) @(posedge clk);
    #1 check("window end", busy, 0);
    check("cfg ready end", cfg_rdy, 1);
    check("straps held", st, sexp(u, d));
  endtask : do_reset
  task automatic access(logic w, target_t t, logic [4:0] a, logic [15:0] d);
    for (int k = 0; k < 20 && rdy !== 1'b1; k++)
      @(posedge clk);
    @(posedge clk);
    req <= '{1'b1, w, t, a, d};
    @(posedge clk);
    req.valid <= 1'b0;
    #1 check("addr", aout, a);
    check("ram sel", ram_n, t != tgt_ram);
    check("rom sel", rom_n, !(t == tgt_rom && !w));
    check("wr strobe", wr_n, !(w && t == tgt_ram));
    check("ee sel", ee, t == tgt_eeprom && !w);
    check("rd strobe", rd_n, w);
    check("data oe", doe, w && t == tgt_ram);
    @(posedge clk);
    #1 check("done and ready", {done, rdy}, 2'b11);
    if (!w)
      check("rdata", rdata, rexp(t, a));
    if (w && t == tgt_ram)
      model[a] = d;
  endtask : access
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    seed = 54620;
    {rst_n, req, sup, sdat} = '0;
    do_reset(5'h00, 16'h0000);
    do_reset(5'h1f, 16'hffff);
    rv = $random(seed);
    do_reset(rv[4:0], rv[31:16]);
    do_reset(5'h01, 16'h00a5);
    $display("test straps done");
    for (int k = 0; k < 32; k++)
      access(1'b1, tgt_ram, k[4:0], $random(seed));
    for (int k = 0; k < 40; k++)
    begin
      rv = $random(seed);
      access(rv[0], target_t'(rv[2:1] % 2'd3), rv[7:3], rv[31:16]);
    end
    $display("test traffic done");
    do_reset(5'h1e, 16'h005a);
    for (int k = 0; k < 8; k++)
    begin
      rv = $random(seed);
      access(1'b0, target_t'(2'(k % 3)), rv[7:3], 16'h0000);
    end
    $display("test late reset done");
    report_and_stop();
  end
endmodule : mem_side_strap_and_select_test
